// ===== pkg/dsg_pkg.sv
/*
 * shared constants and types of the deep-sleep port clock gate
 * assumes one 250 MHz system clock and a 32-bit classic Wishbone register bus
 */
package dsg_pkg;

    // ****************************************************************
    // sizes
    // ****************************************************************
    localparam int NUM_PORTS = 8;
    localparam int PORT_IDX_W = 3;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 12;
    localparam int WORD_LSB = 2;

    // ****************************************************************
    // register byte offsets
    // ****************************************************************
    localparam logic [ADDR_W-1:0] REG_RUN_CFG = 12'h060;
    localparam logic [ADDR_W-1:0] REG_RUN_GATE = 12'h108;
    localparam logic [ADDR_W-1:0] REG_SLEEP_GATE = 12'h118;
    localparam logic [ADDR_W-1:0] REG_DEEP_GATE = 12'h128;
    localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 12'h150;
    localparam logic [ADDR_W-1:0] REG_IRQ_ENABLE = 12'h154;
    localparam logic [ADDR_W-1:0] REG_IRQ_CLEAR = 12'h158;

    // ****************************************************************
    // fields and reset values
    // ****************************************************************
    localparam int AUTO_GATE_POS = 0;
    localparam int GATE_LANE = 0;
    localparam logic [NUM_PORTS-1:0] GATE_RESET = 8'h00;
    localparam logic [NUM_PORTS-1:0] IRQ_RESET = 8'h00;
    localparam logic AUTO_GATE_RESET = 1'b0;
    localparam logic [DATA_W-1:0] READ_ZERO = 32'h00000000;
    localparam logic [DATA_W-NUM_PORTS-1:0] RSVD_ZERO = 24'h000000;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [1:0] {
        DSG_PWR_RUN,
        DSG_PWR_SLEEP,
        DSG_PWR_DEEP
    } dsg_pwr_e;

    typedef struct packed {
        logic [NUM_PORTS-1:0] run_gate;
        logic [NUM_PORTS-1:0] sleep_gate;
        logic [NUM_PORTS-1:0] deep_gate;
        logic auto_gate;
    } dsg_gate_cfg_s;

    typedef struct packed {
        logic valid;
        logic [PORT_IDX_W-1:0] idx;
    } dsg_port_acc_s;

endpackage : dsg_pkg

// ===== logic/dsg_gate_sel.sv
/*
 * picks the gating vector that applies in the current power state
 * assumes the power state comes from logic on the system clock
 */
`timescale 1ns/1ps
module dsg_gate_sel (
    input wire dsg_pkg::dsg_gate_cfg_s cfg_i,
    input wire dsg_pkg::dsg_pwr_e pwr_i,
    output logic [dsg_pkg::NUM_PORTS-1:0] en_o
);
    import dsg_pkg::*;

    // ****************************************************************
    // selection
    // ****************************************************************
    always_comb begin
        en_o = cfg_i.run_gate; // RULE9
        if (cfg_i.auto_gate) begin // RULE7
            case (pwr_i) // RULE6
                DSG_PWR_RUN: begin
                    en_o = cfg_i.run_gate;
                end
                DSG_PWR_SLEEP: begin
                    en_o = cfg_i.sleep_gate;
                end
                DSG_PWR_DEEP: begin
                    en_o = cfg_i.deep_gate; // RULE1
                end
                default: begin
                    en_o = cfg_i.run_gate;
                end
            endcase
        end
    end

endmodule : dsg_gate_sel

// ===== logic/dsg_fault_chk.sv
/*
 * flags a port access that targets a unit whose clock is off
 * assumes the access strobe is a one-cycle pulse on the system clock
 */
`timescale 1ns/1ps
module dsg_fault_chk (
    input wire dsg_pkg::dsg_port_acc_s acc_i,
    input wire [dsg_pkg::NUM_PORTS-1:0] en_i,
    output logic [dsg_pkg::NUM_PORTS-1:0] fault_o
);
    import dsg_pkg::*;

    // ****************************************************************
    // per-port decode
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < NUM_PORTS; g++) begin : g_port
            assign fault_o[g] = acc_i.valid && (acc_i.idx == PORT_IDX_W'(g)) && !en_i[g]; // RULE3
        end
    endgenerate

endmodule : dsg_fault_chk

// ===== logic/dsg_top.sv
/*
 * deep-sleep port clock gate: gating registers, Wishbone slave, fault
 * detection for gated ports and a fault interrupt
 * assumes power state and port accesses come from logic on clk_i
 */
// What this block does
// RULE1: deep-sleep gating bit set delivers the clock to that port in deep-sleep.
// RULE2: deep-sleep gating bit clear withholds that port's clock in deep-sleep.
// RULE3: an access to a port whose clock is off answers with a fault.
// RULE4: all gating bits reset to zero, so every port starts unclocked.
// RULE5: eight read-write bits, bit 0 port A up to bit 7 port H.
// RULE6: separate run, sleep and deep-sleep registers, chosen by power state.
// RULE7: sleep and deep-sleep settings apply only with automatic gating set.
// RULE8: bits 31:8 are read-only and read as zero.
// RULE9: without automatic gating the run settings apply in every power state.
`timescale 1ns/1ps
module dsg_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [dsg_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [dsg_pkg::DATA_W-1:0] wb_dat_i,
    output logic [dsg_pkg::DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    input wire dsg_pkg::dsg_pwr_e pwr_state_i,
    input wire dsg_pkg::dsg_port_acc_s port_acc_i,
    output logic [dsg_pkg::NUM_PORTS-1:0] port_clk_en_o,
    output logic port_fault_o,
    output logic port_ok_o,
    output logic irq_o
);
    import dsg_pkg::*;

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        dsg_gate_cfg_s cfg;
        logic [NUM_PORTS-1:0] irq_stat;
        logic [NUM_PORTS-1:0] irq_en;
        logic [NUM_PORTS-1:0] clk_en;
        logic fault;
        logic ok;
        logic irq;
        logic ack;
        logic err;
        logic [DATA_W-1:0] dat;
    } dsg_state_s;

    dsg_state_s state_reg;
    dsg_state_s state_next;
    logic [NUM_PORTS-1:0] eff_en;
    logic [NUM_PORTS-1:0] fault_vec;

    function automatic logic hit(input logic [ADDR_W-1:0] adr, input logic [ADDR_W-1:0] off);
        hit = (adr[ADDR_W-1:WORD_LSB] == off[ADDR_W-1:WORD_LSB]);
    endfunction : hit

    function automatic logic mapped(input logic [ADDR_W-1:0] adr);
        mapped = hit(adr, REG_RUN_CFG) || hit(adr, REG_RUN_GATE) || hit(adr, REG_SLEEP_GATE)
            || hit(adr, REG_DEEP_GATE) || hit(adr, REG_IRQ_STATUS)
            || hit(adr, REG_IRQ_ENABLE) || hit(adr, REG_IRQ_CLEAR);
    endfunction : mapped

    // ****************************************************************
    // gating selection and fault check
    // ****************************************************************
    dsg_gate_sel u_sel (
        .cfg_i(state_reg.cfg),
        .pwr_i(pwr_state_i),
        .en_o(eff_en)
    );

    // fault is judged against the clock enable the port really sees now
    dsg_fault_chk u_chk (
        .acc_i(port_acc_i),
        .en_i(state_reg.clk_en),
        .fault_o(fault_vec)
    );

    // ****************************************************************
    // next state
    // ****************************************************************
    logic req;
    logic wr_commit;
    logic [NUM_PORTS-1:0] clr_mask;
    logic [DATA_W-1:0] rd_val;

    always_comb begin
        state_next = state_reg;
        req = wb_cyc_i && wb_stb_i;
        // writes take effect at the edge where the master sees ack
        wr_commit = req && wb_we_i && state_reg.ack && wb_sel_i[GATE_LANE];
        clr_mask = '0;
        rd_val = READ_ZERO;
        if (hit(wb_adr_i, REG_RUN_CFG)) begin
            rd_val[AUTO_GATE_POS] = state_reg.cfg.auto_gate;
        end else if (hit(wb_adr_i, REG_RUN_GATE)) begin
            rd_val = {RSVD_ZERO, state_reg.cfg.run_gate};
        end else if (hit(wb_adr_i, REG_SLEEP_GATE)) begin
            rd_val = {RSVD_ZERO, state_reg.cfg.sleep_gate};
        end else if (hit(wb_adr_i, REG_DEEP_GATE)) begin
            rd_val = {RSVD_ZERO, state_reg.cfg.deep_gate}; // RULE8
        end else if (hit(wb_adr_i, REG_IRQ_STATUS)) begin
            rd_val = {RSVD_ZERO, state_reg.irq_stat};
        end else if (hit(wb_adr_i, REG_IRQ_ENABLE)) begin
            rd_val = {RSVD_ZERO, state_reg.irq_en};
        end
        // ack or err rises one cycle after the request and drops after one
        state_next.ack = req && !state_reg.ack && !state_reg.err && mapped(wb_adr_i);
        state_next.err = req && !state_reg.ack && !state_reg.err && !mapped(wb_adr_i);
        state_next.dat = state_next.ack ? rd_val : READ_ZERO;
        if (wr_commit) begin
            if (hit(wb_adr_i, REG_RUN_CFG)) begin
                state_next.cfg.auto_gate = wb_dat_i[AUTO_GATE_POS]; // RULE7
            end
            if (hit(wb_adr_i, REG_RUN_GATE)) begin
                state_next.cfg.run_gate = wb_dat_i[NUM_PORTS-1:0];
            end
            if (hit(wb_adr_i, REG_SLEEP_GATE)) begin
                state_next.cfg.sleep_gate = wb_dat_i[NUM_PORTS-1:0];
            end
            if (hit(wb_adr_i, REG_DEEP_GATE)) begin
                state_next.cfg.deep_gate = wb_dat_i[NUM_PORTS-1:0]; // RULE5
            end
            if (hit(wb_adr_i, REG_IRQ_ENABLE)) begin
                state_next.irq_en = wb_dat_i[NUM_PORTS-1:0];
            end
            if (hit(wb_adr_i, REG_IRQ_CLEAR)) begin
                clr_mask = wb_dat_i[NUM_PORTS-1:0];
            end
        end
        // a fault in the clearing cycle survives the clear
        state_next.irq_stat = (state_reg.irq_stat & ~clr_mask) | fault_vec;
        state_next.irq = |(state_next.irq_stat & state_next.irq_en);
        state_next.clk_en = eff_en; // RULE1 RULE2
        state_next.fault = |fault_vec; // RULE3
        state_next.ok = port_acc_i.valid && !(|fault_vec);
        if (rst_i) begin
            state_next.cfg.run_gate = GATE_RESET;
            state_next.cfg.sleep_gate = GATE_RESET;
            state_next.cfg.deep_gate = GATE_RESET; // RULE4
            state_next.cfg.auto_gate = AUTO_GATE_RESET;
            state_next.irq_stat = IRQ_RESET;
            state_next.irq_en = IRQ_RESET;
            state_next.clk_en = GATE_RESET;
            state_next.fault = 1'b0;
            state_next.ok = 1'b0;
            state_next.irq = 1'b0;
            state_next.ack = 1'b0;
            state_next.err = 1'b0;
            state_next.dat = READ_ZERO;
        end
    end

    always_ff @(posedge clk_i) begin
        state_reg <= state_next;
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign wb_dat_o = state_reg.dat;
    assign wb_ack_o = state_reg.ack;
    assign wb_err_o = state_reg.err;
    assign port_clk_en_o = state_reg.clk_en;
    assign port_fault_o = state_reg.fault;
    assign port_ok_o = state_reg.ok;
    assign irq_o = state_reg.irq;

    // ****************************************************************
    // checks
    // ****************************************************************
    logic deep_auto;
    assign deep_auto = (pwr_state_i == DSG_PWR_DEEP) && state_reg.cfg.auto_gate;

    property p_deep_on;
        @(posedge clk_i) disable iff (rst_i)
        deep_auto |=> ((port_clk_en_o & $past(state_reg.cfg.deep_gate))
            == $past(state_reg.cfg.deep_gate));
    endproperty
    a_deep_on: assert property (p_deep_on) else $error("deep-sleep enabled port not clocked"); // RULE1

    property p_deep_off;
        @(posedge clk_i) disable iff (rst_i)
        deep_auto |=> ((port_clk_en_o & ~$past(state_reg.cfg.deep_gate)) == GATE_RESET);
    endproperty
    a_deep_off: assert property (p_deep_off) else $error("deep-sleep disabled port clocked"); // RULE2

    property p_fault;
        @(posedge clk_i) disable iff (rst_i)
        (port_acc_i.valid && !port_clk_en_o[port_acc_i.idx]) |=> (port_fault_o && !port_ok_o);
    endproperty
    a_fault: assert property (p_fault) else $error("gated port access did not fault"); // RULE3

    property p_reset;
        @(posedge clk_i) disable iff (1'b0)
        rst_i |=> (state_reg.cfg.deep_gate == GATE_RESET) && (port_clk_en_o == GATE_RESET);
    endproperty
    a_reset: assert property (p_reset) else $error("gating bits not zero after reset"); // RULE4

    property p_deep_write;
        @(posedge clk_i) disable iff (rst_i)
        (wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[GATE_LANE]
            && hit(wb_adr_i, REG_DEEP_GATE))
        |=> state_reg.cfg.deep_gate == $past(wb_dat_i[NUM_PORTS-1:0]);
    endproperty
    a_deep_write: assert property (p_deep_write) else $error("deep-sleep write lost"); // RULE5

    property p_sleep_sel;
        @(posedge clk_i) disable iff (rst_i)
        ((pwr_state_i == DSG_PWR_SLEEP) && state_reg.cfg.auto_gate)
        |=> port_clk_en_o == $past(state_reg.cfg.sleep_gate);
    endproperty
    a_sleep_sel: assert property (p_sleep_sel) else $error("sleep gating not applied"); // RULE6

    property p_run_sel;
        @(posedge clk_i) disable iff (rst_i)
        (pwr_state_i == DSG_PWR_RUN) |=> port_clk_en_o == $past(state_reg.cfg.run_gate);
    endproperty
    a_run_sel: assert property (p_run_sel) else $error("run gating not applied"); // RULE7

    property p_rsvd;
        @(posedge clk_i) disable iff (rst_i)
        (req && !wb_ack_o && !wb_we_i && hit(wb_adr_i, REG_DEEP_GATE))
        |=> wb_ack_o && (wb_dat_o[DATA_W-1:NUM_PORTS] == RSVD_ZERO);
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits read nonzero"); // RULE8

    property p_no_auto;
        @(posedge clk_i) disable iff (rst_i)
        !state_reg.cfg.auto_gate |=> port_clk_en_o == $past(state_reg.cfg.run_gate);
    endproperty
    a_no_auto: assert property (p_no_auto) else $error("run gating ignored without auto"); // RULE9

    property p_ack_pulse;
        @(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held longer than one cycle");

    property p_err_pulse;
        @(posedge clk_i) disable iff (rst_i)
        wb_err_o |=> !wb_err_o;
    endproperty
    a_err_pulse: assert property (p_err_pulse) else $error("err held longer than one cycle");

    property p_one_answer;
        @(posedge clk_i) disable iff (rst_i)
        !(wb_ack_o && wb_err_o);
    endproperty
    a_one_answer: assert property (p_one_answer) else $error("ack and err together");

    property p_answer;
        @(posedge clk_i) disable iff (rst_i)
        (req && !wb_ack_o && !wb_err_o) |=> (wb_ack_o || wb_err_o);
    endproperty
    a_answer: assert property (p_answer) else $error("request not answered next cycle");

    property p_dat_idle;
        @(posedge clk_i) disable iff (rst_i)
        !wb_ack_o |-> (wb_dat_o == READ_ZERO);
    endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");

    property p_ok;
        @(posedge clk_i) disable iff (rst_i)
        (port_acc_i.valid && port_clk_en_o[port_acc_i.idx]) |=> (port_ok_o && !port_fault_o);
    endproperty
    a_ok: assert property (p_ok) else $error("clocked port access faulted"); // RULE1

    property p_no_acc;
        @(posedge clk_i) disable iff (rst_i)
        !port_acc_i.valid |=> !(port_fault_o || port_ok_o);
    endproperty
    a_no_acc: assert property (p_no_acc) else $error("port answer without access");

    property p_stat_set;
        @(posedge clk_i) disable iff (rst_i)
        (port_acc_i.valid && !port_clk_en_o[port_acc_i.idx])
        |=> state_reg.irq_stat[$past(port_acc_i.idx)];
    endproperty
    a_stat_set: assert property (p_stat_set) else $error("fault status bit not set"); // RULE3

    property p_irq_level;
        @(posedge clk_i) disable iff (rst_i)
        irq_o == (|(state_reg.irq_stat & state_reg.irq_en));
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq does not follow status");

    property p_deep_no_auto;
        @(posedge clk_i) disable iff (rst_i)
        ((pwr_state_i == DSG_PWR_DEEP) && !state_reg.cfg.auto_gate)
        |=> port_clk_en_o == $past(state_reg.cfg.run_gate);
    endproperty
    a_deep_no_auto: assert property (p_deep_no_auto) else $error("deep gate applied"); // RULE7

    property p_reset_out;
        @(posedge clk_i) disable iff (1'b0)
        rst_i |=> !(wb_ack_o || wb_err_o || port_fault_o || port_ok_o || irq_o);
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("outputs active after reset");

    c_deep_gated: cover property (@(posedge clk_i) disable iff (rst_i) deep_auto ##1 port_fault_o);
    c_deep_clocked: cover property (@(posedge clk_i) disable iff (rst_i) deep_auto ##1 port_ok_o);
    c_irq: cover property (@(posedge clk_i) disable iff (rst_i) irq_o);
    c_err: cover property (@(posedge clk_i) disable iff (rst_i) wb_err_o);
    c_sel_ignored: cover property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o && wb_we_i && !wb_sel_i[GATE_LANE]);

endmodule : dsg_top

// ===== sim/dsg_port_model.sv
/*
 * model of the gated port units: turns a cpu access request into the
 * one-cycle access pulse that reaches the clock gate
 * assumes one request cycle at a time from the bench, on clk_i
 */
`timescale 1ns/1ps
module dsg_port_model
    import dsg_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire dsg_pkg::dsg_port_acc_s req_i,
    output dsg_pkg::dsg_port_acc_s acc_o
);
    // idle cycles show a changing index so a stale one is never trusted
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc_o <= '0;
        end else if (req_i.valid) begin
            acc_o <= req_i;
        end else begin
            acc_o <= '{valid: 1'b0, idx: ~acc_o.idx};
        end
    end
endmodule : dsg_port_model

// ===== sim/deep_sleep_port_clock_gate_tb.sv
/*
 * self-checking bench of the deep-sleep port clock gate
 * assumes dsg_top with a 4 ns clock and the port unit model beside it
 */
`timescale 1ns/1ps
module deep_sleep_port_clock_gate_tb;
    import dsg_pkg::*;
    typedef struct packed {
        logic auto_gate;
        dsg_pwr_e pwr;
        logic [7:0] run;
        logic [7:0] slp;
        logic [7:0] dp;
        logic [7:0] exp;
    } dsg_row_s;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [11:0] wb_adr_i = 12'h000;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h00000000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic wb_err_o;
    dsg_pwr_e pwr_state_i = DSG_PWR_RUN;
    dsg_port_acc_s req = '0;
    dsg_port_acc_s port_acc_i;
    logic [7:0] port_clk_en_o;
    logic port_fault_o;
    logic port_ok_o;
    logic irq_o;
    int num_errors = 0;
    int num_checks = 0;
    logic [31:0] rdat;
    logic rerr;
    dsg_row_s rows [5] = '{
        '{1'b0, DSG_PWR_DEEP, 8'hA5, 8'hFF, 8'h00, 8'hA5},
        '{1'b0, DSG_PWR_SLEEP, 8'h5A, 8'h0F, 8'hF0, 8'h5A},
        '{1'b1, DSG_PWR_RUN, 8'hC3, 8'h81, 8'h18, 8'hC3},
        '{1'b1, DSG_PWR_SLEEP, 8'hC3, 8'h81, 8'h18, 8'h81},
        '{1'b1, DSG_PWR_DEEP, 8'h00, 8'hFF, 8'h3C, 8'h3C}};

    always #2 clk_i = ~clk_i;

    dsg_port_model u_model (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .acc_o(port_acc_i));
    dsg_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
        .pwr_state_i(pwr_state_i), .port_acc_i(port_acc_i), .port_clk_en_o(port_clk_en_o),
        .port_fault_o(port_fault_o), .port_ok_o(port_ok_o), .irq_o(irq_o));

    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // holds the request until ack or err, the master never assumes a latency
    task automatic wb(input logic we, input logic [11:0] adr, input logic [31:0] dat,
        input logic [3:0] sel);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= sel;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
        if (n >= 20) num_errors++;
        rdat = wb_dat_o;
        rerr = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask : wb

    task automatic wr(input logic [11:0] adr, input logic [31:0] dat);
        wb(1'b1, adr, dat, 4'hF);
    endtask : wr

    task automatic rdc(input string name, input logic [11:0] adr, input logic [31:0] exp);
        wb(1'b0, adr, 32'h00000000, 4'hF);
        check(name, rdat, exp);
    endtask : rdc

    // fault or ok appears one edge after the model forwards the request
    task automatic port_acc(input int k, input logic fault);
        @(posedge clk_i);
        req <= '{valid: 1'b1, idx: k[2:0]};
        @(posedge clk_i);
        req <= '{valid: 1'b0, idx: 3'h0};
        repeat (2) @(posedge clk_i);
        check("port_fault_o", {31'h00000000, port_fault_o}, {31'h00000000, fault});
        check("port_ok_o", {31'h00000000, port_ok_o}, {31'h00000000, ~fault});
    endtask : port_acc

    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict

    // ****************************************************************
    // sequence
    // ****************************************************************
    initial begin
        #40000;
        num_errors++;
        print_verdict();
    end

    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (rows[i]) begin
            wr(REG_RUN_GATE, {24'h000000, rows[i].run});
            wr(REG_SLEEP_GATE, {24'h000000, rows[i].slp});
            wr(REG_DEEP_GATE, {24'h000000, rows[i].dp});
            wr(REG_RUN_CFG, {31'h00000000, rows[i].auto_gate});
            pwr_state_i <= rows[i].pwr;
            rdc("deep gate", REG_DEEP_GATE, {24'h000000, rows[i].dp});
            rdc("auto gate", REG_RUN_CFG, {31'h00000000, rows[i].auto_gate});
            check("port_clk_en_o", port_clk_en_o, rows[i].exp);
            for (int k = 0; k < 8; k++) port_acc(k, ~rows[i].exp[k]);
        end
        // software keeps reserved bits zero; the device must drop them anyway
        wr(REG_DEEP_GATE, 32'hFFFFFFFF);
        rdc("deep reserved", REG_DEEP_GATE, 32'h000000FF);
        wb(1'b1, REG_DEEP_GATE, 32'h00000000, 4'hE);
        rdc("deep lane0 off", REG_DEEP_GATE, 32'h000000FF);
        wb(1'b0, 12'h200, 32'h00000000, 4'hF);
        check("wb_err_o", {31'h00000000, rerr}, 32'h00000001);
        wr(REG_IRQ_CLEAR, 32'h000000FF);
        wr(REG_IRQ_ENABLE, 32'h00000001);
        rdc("irq enable", REG_IRQ_ENABLE, 32'h00000001);
        rdc("irq clear reads zero", REG_IRQ_CLEAR, 32'h00000000);
        wr(REG_DEEP_GATE, 32'h000000FE);
        repeat (2) @(posedge clk_i);
        port_acc(0, 1'b1);
        wr(REG_IRQ_STATUS, 32'h00000000);
        rdc("irq status", REG_IRQ_STATUS, 32'h00000001);
        check("irq_o", {31'h00000000, irq_o}, 32'h00000001);
        wr(REG_IRQ_ENABLE, 32'h00000000);
        repeat (2) @(posedge clk_i);
        check("irq_o masked", {31'h00000000, irq_o}, 32'h00000000);
        wr(REG_IRQ_ENABLE, 32'h00000001);
        wr(REG_IRQ_CLEAR, 32'h00000001);
        repeat (2) @(posedge clk_i);
        check("irq_o cleared", {31'h00000000, irq_o}, 32'h00000000);
        rdc("irq status", REG_IRQ_STATUS, 32'h00000000);
        // second reset in mid-run: every gating bit returns to zero
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc("deep after reset", REG_DEEP_GATE, 32'h00000000);
        rdc("run after reset", REG_RUN_GATE, 32'h00000000);
        rdc("sleep after reset", REG_SLEEP_GATE, 32'h00000000);
        rdc("auto after reset", REG_RUN_CFG, 32'h00000000);
        check("port_clk_en_o", port_clk_en_o, 32'h00000000);
        print_verdict();
    end
endmodule : deep_sleep_port_clock_gate_tb
